// ---- shared/ifa_pkg.sv ----
// constants and carrier types for the input frame offset aligner
// assumes one system clock; serial clock and frame pulse arrive as plain pins
package ifa_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned N_STREAMS = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned ADDR_W = 4;
    // register word indices on the plain register port
    localparam logic [3:0] ADDR_OFS_LO = 4'h0;
    localparam logic [3:0] ADDR_OFS_HI = 4'h1;
    localparam logic [3:0] ADDR_CTRL = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    // field layout: 4 bits per stream, offset in [3:1], latch edge in [0]
    localparam int unsigned FIELD_W = 4;
    localparam int unsigned OFS_MSB = 3;
    localparam int unsigned OFS_LSB = 1;
    localparam int unsigned DLE_BIT = 0;
    localparam logic [2:0] OFS_MAX = 3'h4;
    localparam logic [15:0] OFS_RESET = 16'h0000;
    localparam int unsigned CTRL_GCI_BIT = 0;
    localparam int unsigned STAT_HALF_BIT = 8;
    localparam int unsigned BIT_CNT_LAST = 7;

    typedef struct packed {
        logic [2:0] offset;
        logic latch_edge;
    } ifa_field_s;

    typedef struct packed {
        logic [2:0] stream;
        logic [7:0] data;
    } ifa_byte_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ifa_bus_s;
endpackage

// ---- logic/ifa_align.sv ----
// input frame offset aligner: per-stream frame start delay, latch edge choice,
// byte assembly and a 16-word fifo toward the switch core.
// assumes ser_clk is far slower than clk (at least 6 clk per ser_clk period)
// How it works
// [RQ1] each stream has a 4-bit field: 3 offset bits above one latch-edge bit
// [RQ2] offset bits set how long after frame pulse bit 0 is stored
// [RQ3] offset reaches up to 4 clock periods; latch edge adds a half
// [RQ4] primary mode, latch edge 0: sample on rising edge at 3/4 cell
// [RQ5] primary mode, latch edge 1: sample on falling edge at 3/4 cell
// [RQ6] gci mode, latch edge 0: sample on falling edge at 3/4 cell
// [RQ7] gci mode, latch edge 1: sample on rising edge at 3/4 cell
// [RQ8] all four bits zero means no shift, the default
// [RQ9] latch edge alone shifts half a period; each offset step adds one
// [RQ10] software copies measured low delay bits and inverts the half bit
// [RQ11] 4.5 periods is offset 100 with latch edge 1; nothing larger
// [RQ12] half-phase bit records clock level when the frame pulse edge came
// [RQ13] software zeroes offset bits of streams in loopback
// [RQ14] new settings take effect at the next frame boundary; here the gci flag takes effect at once
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns

module ifa_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // honest full and empty from the occupancy count
    assign in_ready = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];

    // storage has no reset, pointers do
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= push ? wp_r + 1'b1 : wp_r;
            rp_r <= pop ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    fifo_full_a: assert property (@(posedge clk) disable iff (!nrst)
        cnt_r == (PW+1)'(DEPTH) |-> !in_ready && !push)
        else $error("fifo accepted a word while full");
endmodule

module ifa_align (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ser_clk,
    input wire logic frame_pin,
    input wire logic [7:0] rx_pin,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic out_valid,
    output ifa_pkg::ifa_byte_s out_data,
    input wire logic out_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // two-stage synchronisers for every pin input
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic frm_s1_r, frm_s2_r, frm_s3_r;
    logic [7:0] rx_s1_r, rx_s2_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
            {frm_s1_r, frm_s2_r, frm_s3_r} <= 3'h7;
            rx_s1_r <= 8'h00;
            rx_s2_r <= 8'h00;
        end else begin
            {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {ser_clk, sclk_s1_r, sclk_s2_r};
            {frm_s1_r, frm_s2_r, frm_s3_r} <= {frame_pin, frm_s1_r, frm_s2_r};
            rx_s1_r <= rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    // registers written by software, plus active settings, status and read data kept by hardware
    logic [15:0] ofs_lo_r, ofs_hi_r;
    logic gci_r;
    logic [31:0] act_r;
    logic half_phase_r;
    logic [7:0] overrun_r;
    logic [15:0] rdata_r;

    // edge detection on synchronised levels only (second stage onward)
    wire sclk_rise = sclk_s2_r && !sclk_s3_r;
    wire sclk_fall = !sclk_s2_r && sclk_s3_r;
    // frame pulse is low-active in primary mode, high-active in gci mode
    wire frame_edge = gci_r ? (frm_s2_r && !frm_s3_r) : (!frm_s2_r && frm_s3_r);
    wire [31:0] ofs_all = {ofs_hi_r, ofs_lo_r};

    // clamp an undefined offset to the largest defined one
    function automatic logic [3:0] clamp_field(input logic [3:0] f);
        ifa_pkg::ifa_field_s fs;
        fs = f;
        if (fs.offset > ifa_pkg::OFS_MAX) begin // see RQ11
            fs.offset = ifa_pkg::OFS_MAX;
        end
        return fs;
    endfunction

    // slice one stream's field out of the packed settings
    function automatic ifa_pkg::ifa_field_s field_of(input logic [31:0] cfg,
                                                      input int unsigned n);
        return cfg[n*ifa_pkg::FIELD_W +: ifa_pkg::FIELD_W]; // see RQ1
    endfunction

    // register decode
    wire wr_lo = reg_wr && (reg_addr == ifa_pkg::ADDR_OFS_LO);
    wire wr_hi = reg_wr && (reg_addr == ifa_pkg::ADDR_OFS_HI);
    wire wr_ctrl = reg_wr && (reg_addr == ifa_pkg::ADDR_CTRL);
    wire wr_stat = reg_wr && (reg_addr == ifa_pkg::ADDR_STATUS);
    logic [7:0] ovr_set;
    wire [7:0] overrun_nxt = ovr_set | (overrun_r & ~(wr_stat ? reg_wdata[7:0] : 8'h00));
    wire [15:0] status_word = {7'h00, half_phase_r, overrun_r};
    wire [15:0] rdata_nxt =
        !reg_rd ? 16'h0000 :
        (reg_addr == ifa_pkg::ADDR_OFS_LO) ? ofs_lo_r :
        (reg_addr == ifa_pkg::ADDR_OFS_HI) ? ofs_hi_r :
        (reg_addr == ifa_pkg::ADDR_CTRL) ? {15'h0000, gci_r} :
        (reg_addr == ifa_pkg::ADDR_STATUS) ? status_word : 16'h0000;

    // offset and latch edge settings only reach the receivers at a frame boundary; the gci flag acts at once
    logic [31:0] act_nxt;
    always_comb begin
        act_nxt = act_r;
        if (frame_edge) begin
            for (int i = 0; i < ifa_pkg::N_STREAMS; i++) begin
                act_nxt[i*ifa_pkg::FIELD_W +: ifa_pkg::FIELD_W] =
                    clamp_field(ofs_all[i*ifa_pkg::FIELD_W +: ifa_pkg::FIELD_W]); // see RQ14
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ofs_lo_r <= ifa_pkg::OFS_RESET; // see RQ8
            ofs_hi_r <= ifa_pkg::OFS_RESET;
            gci_r <= 1'b0;
            act_r <= 32'h0000_0000;
            half_phase_r <= 1'b0;
            overrun_r <= 8'h00;
            rdata_r <= 16'h0000;
        end else begin
            ofs_lo_r <= wr_lo ? reg_wdata : ofs_lo_r;
            ofs_hi_r <= wr_hi ? reg_wdata : ofs_hi_r;
            gci_r <= wr_ctrl ? reg_wdata[ifa_pkg::CTRL_GCI_BIT] : gci_r;
            act_r <= act_nxt;
            // clock level at the frame edge, half-period resolution
            half_phase_r <= frame_edge ? sclk_s2_r : half_phase_r; // see RQ12
            overrun_r <= overrun_nxt; // set wins over write-one-to-clear
            rdata_r <= rdata_nxt;
        end
    end
    assign reg_rdata = rdata_r;

    // per-stream receivers
    logic [7:0] hold_pend;
    logic [7:0] grant;
    ifa_pkg::ifa_byte_s hold_data [8];
    logic fifo_in_ready;

    for (genvar g = 0; g < ifa_pkg::N_STREAMS; g++) begin : g_rx
        ifa_pkg::ifa_field_s fld;
        logic [2:0] wait_r;
        logic phase_r, run_r, pend_r;
        logic [2:0] bit_r;
        logic [7:0] shift_r, hold_r;
        assign fld = field_of(act_r, g);
        // clamped field from the live registers, loaded at the frame edge
        ifa_pkg::ifa_field_s ld_fld;
        assign ld_fld = clamp_field(ofs_all[g*ifa_pkg::FIELD_W +: ifa_pkg::FIELD_W]);
        // rising edge chosen when latch edge equals the gci flag
        wire use_rise = (fld.latch_edge == gci_r); // see RQ4 RQ5 RQ6 RQ7
        wire sel_edge = use_rise ? sclk_rise : sclk_fall;
        // whole periods first, then every second chosen edge is the 3/4 point
        wire skip = run_r && sel_edge && (wait_r != 3'h0); // see RQ2 RQ3 RQ9
        wire sample = run_r && sel_edge && (wait_r == 3'h0) && phase_r;
        wire byte_done = sample && (bit_r == 3'(ifa_pkg::BIT_CNT_LAST));
        assign hold_pend[g] = pend_r;
        assign hold_data[g] = '{stream: 3'(g), data: hold_r};
        assign ovr_set[g] = byte_done && pend_r && !grant[g];

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                wait_r <= 3'h0;
                phase_r <= 1'b0;
                run_r <= 1'b0;
                bit_r <= 3'h0;
                shift_r <= 8'h00;
            end else if (frame_edge) begin
                wait_r <= ld_fld.offset; // see RQ3
                phase_r <= 1'b0;
                run_r <= 1'b1;
                bit_r <= 3'h0;
            end else begin
                wait_r <= skip ? wait_r - 3'h1 : wait_r;
                phase_r <= (run_r && sel_edge && wait_r == 3'h0) ? !phase_r : phase_r;
                bit_r <= sample ? bit_r + 3'h1 : bit_r;
                shift_r <= sample ? {shift_r[6:0], rx_s2_r[g]} : shift_r;
            end
        end

        // finished byte waits here until the fifo takes it
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                pend_r <= 1'b0;
                hold_r <= 8'h00;
            end else begin
                pend_r <= byte_done || (pend_r && !grant[g]);
                hold_r <= byte_done ? {shift_r[6:0], rx_s2_r[g]} : hold_r;
            end
        end

        // chosen edges since the frame edge; check aid only, kept apart from wait_r
        logic [3:0] edge_cnt_r;
        logic first_r;
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                edge_cnt_r <= 4'h0;
                first_r <= 1'b0;
            end else if (frame_edge) begin
                edge_cnt_r <= 4'h0;
                first_r <= 1'b1;
            end else begin
                edge_cnt_r <= (sel_edge && edge_cnt_r != 4'hf) ? edge_cnt_r + 4'h1 : edge_cnt_r;
                first_r <= first_r && !sample;
            end
        end

        // sequences for the frame start and the first stored bit
        sequence frame_load_s;
            frame_edge ##1 run_r && (bit_r == 3'h0);
        endsequence
        sequence first_sample_s;
            first_r && sample;
        endsequence

        load_wait_a: assert property (frame_load_s |-> // see RQ2
            wait_r == (($past(ofs_all[g*4+1 +: 3]) > 3'h4) ? 3'h4 : $past(ofs_all[g*4+1 +: 3])))
            else $error("offset wait not loaded from field at frame edge");
        first_bit_a: assert property (first_sample_s |-> // see RQ2 RQ3
            edge_cnt_r == {1'b0, fld.offset} + 4'h1)
            else $error("first bit not on the chosen edge after the offset");
        prim_edge_a: assert property (!gci_r && sample |-> // see RQ4 RQ5
            (fld.latch_edge ? $fell(sclk_s2_r) : $rose(sclk_s2_r)))
            else $error("primary mode sampled on wrong clock edge");
        gci_edge_a: assert property (gci_r && sample |-> // see RQ6 RQ7
            (fld.latch_edge ? $rose(sclk_s2_r) : $fell(sclk_s2_r)))
            else $error("gci mode sampled on wrong clock edge");
        zero_shift_a: assert property (first_sample_s ##0 (fld == 4'h0 && !gci_r) |-> // see RQ8
            edge_cnt_r == 4'h1 && $rose(sclk_s2_r))
            else $error("default field did not sample on second rising edge");
    end

    // fixed priority pick of one pending byte per cycle toward the fifo
    assign grant = fifo_in_ready ? (hold_pend & (~hold_pend + 8'h01)) : 8'h00;
    logic [2:0] gidx;
    always_comb begin
        gidx = 3'h0;
        for (int i = ifa_pkg::N_STREAMS - 1; i >= 0; i--) begin
            if (hold_pend[i]) begin
                gidx = 3'(i);
            end
        end
    end

    wire fifo_out_valid;
    ifa_pkg::ifa_byte_s fifo_out_data;
    logic ov_r;
    ifa_pkg::ifa_byte_s od_r;
    // output stage keeps ports on flops; fifo drains only when it is free
    wire stage_take = !ov_r || out_ready;

    ifa_fifo #(.WIDTH($bits(ifa_pkg::ifa_byte_s)), .DEPTH(ifa_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(|hold_pend),
        .in_ready(fifo_in_ready),
        .in_data(hold_data[gidx]),
        .out_valid(fifo_out_valid),
        .out_ready(stage_take),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ov_r <= 1'b0;
            od_r <= '0;
        end else if (stage_take) begin
            ov_r <= fifo_out_valid;
            od_r <= fifo_out_valid ? fifo_out_data : od_r;
        end
    end
    assign out_valid = ov_r;
    assign out_data = od_r;

    cfg_apply_a: assert property (frame_edge |=> // see RQ14
        act_r[31:29] == (($past(ofs_hi_r[15:13]) > 3'h4) ? 3'h4 : $past(ofs_hi_r[15:13]))
        && act_r[28] == $past(ofs_hi_r[12]) && act_r[0] == $past(ofs_lo_r[0]))
        else $error("settings not applied at frame edge");
    cfg_hold_a: assert property (!frame_edge |=> $stable(act_r)) // see RQ14
        else $error("settings changed away from frame boundary");
    clamp_a: assert property (act_r[7:5] <= 3'h4 && act_r[31:29] <= 3'h4) // see RQ11
        else $error("active offset above four");
    half_bit_a: assert property (frame_edge |=> half_phase_r == $past(sclk_s2_r)) // see RQ12
        else $error("half-phase bit not captured at frame edge");
    ovr_keep_a: assert property (ovr_set[0] |=> overrun_r[0])
        else $error("overrun set lost against clear");
endmodule

// ---- sim/ifa_src.sv ----
// serial source model: eight streams, frame pulse and stream clock
// assumes clk at 25 MHz; stream clock is clk/8 and stands still while the source is not running
`timescale 1ns/1ns
module ifa_src (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic gci,
    input wire logic [7:0][3:0] dly_nxt,
    input wire logic [7:0][15:0] word_nxt,
    output logic ser_clk,
    output logic frame_pin,
    output logic [7:0] rx_pin,
    output logic frame_start
);
    logic [8:0] pc_r;
    logic act_r;
    logic [7:0][3:0] dly_r;
    logic [7:0][15:0] word_r;
    logic pulse;

    // 320 clk per frame; delays and data latched only between frames
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_r <= 9'h000;
            act_r <= 1'b0;
            dly_r <= '0;
            word_r <= '0;
        end else if (act_r && pc_r != 9'h13f) begin
            pc_r <= pc_r + 9'h001;
        end else begin
            pc_r <= 9'h000;
            act_r <= run;
            dly_r <= dly_nxt;
            word_r <= word_nxt;
        end
    end

    // frame pulse lags the boundary edge by 1 clk so that edge is never counted
    assign pulse = act_r && pc_r >= 9'h001 && pc_r <= 9'h008;
    assign frame_pin = pulse ^ !gci;
    assign ser_clk = act_r ? (pc_r[2] ^ gci) : gci;
    assign frame_start = act_r && pc_r == 9'h000;

    // stream s starts dly_r[s] half periods late; a cell is 16 clk, msb first
    always_comb begin
        int t;
        t = 0;
        for (int s = 0; s < 8; s++) begin
            t = int'(pc_r) - 4 * int'(dly_r[s]);
            rx_pin[s] = (act_r && t >= 0 && t < 256) ? word_r[s][15 - t / 16] : pc_r[0];
        end
    end
endmodule

// ---- sim/tb_ifa_align.sv ----
// self-checking bench for the input frame offset aligner
// assumes the serial source model drives the stream pins
`timescale 1ns/1ns
module tb_ifa_align;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic out_ready = 1'b1;
    logic run = 1'b0;
    logic gci = 1'b0;
    logic hold = 1'b0;
    logic [7:0][3:0] dly_nxt = '0;
    logic [7:0][15:0] word_nxt = '0;
    logic ser_clk, frame_pin, frame_start, out_valid;
    logic [7:0] rx_pin;
    logic [15:0] reg_rdata;
    ifa_pkg::ifa_byte_s out_data;
    logic [7:0] exp_q [8][$];
    int fails = 0;
    int total_checks = 0;

    always #20 clk = ~clk;

    ifa_align u_dut (.clk(clk), .nrst(nrst), .ser_clk(ser_clk), .frame_pin(frame_pin),
        .rx_pin(rx_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready));

    ifa_src u_src (.clk(clk), .nrst(nrst), .run(run), .gci(gci), .dly_nxt(dly_nxt),
        .word_nxt(word_nxt), .ser_clk(ser_clk), .frame_pin(frame_pin), .rx_pin(rx_pin),
        .frame_start(frame_start));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("register", e, reg_rdata & m);
    endtask

    // field value equals delay in half periods: offset whole, latch edge half;
    // stream 7 gets an undefined offset for 4.5 so the clamp is exercised
    // no stream is in loopback here, so nonzero offsets are legal
    function automatic logic [15:0] enc(input int base);
        enc = 16'h0000;
        for (int s = 0; s < 4; s++) begin
            enc[4*s +: 4] = {dly_nxt[base+s][3:1], dly_nxt[base+s][0]};
            if (base + s == 7 && dly_nxt[7] == 4'h9) begin
                enc[4*s +: 4] = 4'hf;
            end
        end
    endfunction

    // consumer with random stalls; bytes checked per stream
    always @(posedge clk) begin
        if (out_valid === 1'b1 && out_ready) begin
            if (exp_q[out_data.stream].size() == 0) begin
                chk("extra byte", 16'h0000, {8'h01, out_data.data});
            end else begin
                chk("byte", {8'h00, exp_q[out_data.stream].pop_front()}, {8'h00, out_data.data});
            end
        end
        out_ready <= !hold && ($urandom_range(3) != 0);
    end

    // new settings written mid-frame must only apply to the next frame
    task automatic frame(input int f);
        int n;
        n = 0;
        do @(posedge clk); while (frame_start !== 1'b1 && ++n < 1000);
        chk("frame start", 16'h0001, {15'h0, frame_start});
        hold <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            exp_q[s].push_back(word_nxt[s][15:8]);
            exp_q[s].push_back(word_nxt[s][7:0]);
            dly_nxt[s] <= (f == 0) ? 4'h9 : (f == 1) ? 4'(s) : 4'($urandom_range(9));
            word_nxt[s] <= 16'($urandom);
        end
        if (f == 5) begin
            run <= 1'b0;
        end
        repeat (20) @(posedge clk);
        wr(ifa_pkg::ADDR_OFS_LO, enc(0));
        wr(ifa_pkg::ADDR_OFS_HI, enc(4));
        rd_chk(ifa_pkg::ADDR_OFS_LO, 16'hffff, enc(0));
        rd_chk(ifa_pkg::ADDR_OFS_HI, 16'hffff, enc(4));
        hold <= (f == 3);
        $display("frame %0d done", f);
    endtask

    task automatic phase(input logic mode);
        run <= 1'b1;
        for (int f = 0; f < 6; f++) begin
            frame(f);
        end
        repeat (400) @(posedge clk);
        wr(ifa_pkg::ADDR_STATUS, 16'h01ff);
        rd_chk(ifa_pkg::ADDR_STATUS, 16'h01ff, {7'h00, mode, 8'h00});
        for (int s = 0; s < 8; s++) begin
            chk("bytes left", 16'h0000, 16'(exp_q[s].size()));
        end
        $display("phase gci %0d done", mode);
    endtask

    initial begin
        void'($urandom(32'hacc32588));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            word_nxt[s] <= 16'($urandom);
        end
        rd_chk(ifa_pkg::ADDR_OFS_LO, 16'hffff, 16'h0000);
        rd_chk(ifa_pkg::ADDR_OFS_HI, 16'hffff, 16'h0000);
        wr(4'h5, 16'hffff);
        rd_chk(4'h5, 16'hffff, 16'h0000);
        rd_chk(ifa_pkg::ADDR_OFS_HI, 16'hffff, 16'h0000);
        phase(1'b0);
        wr(ifa_pkg::ADDR_CTRL, 16'h0001);
        rd_chk(ifa_pkg::ADDR_CTRL, 16'h0001, 16'h0001);
        gci <= 1'b1;
        phase(1'b1);
        stop_test();
    end

    // hang guard: two phases take about 4100 clk
    initial begin
        #800000;
        fails++;
        stop_test();
    end
endmodule
